// ### pmb_pkg.sv
// Shared constants, types and helpers of the PMBus protect/store/mask block.
// Assumes one 40 MHz clock domain and an upstream PMBus framer on that clock.
package pmb_pkg;

    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ONOFF_CFG = 8'h02;
    localparam logic [7:0] CMD_GUARD     = 8'h10;
    localparam logic [7:0] CMD_SAVE      = 8'h11;
    localparam logic [7:0] CMD_RESTORE   = 8'h12;
    localparam logic [7:0] CMD_FEATURE   = 8'h19;
    localparam logic [7:0] CMD_MASK      = 8'h1b;
    localparam logic [7:0] CMD_VOUT      = 8'h21;

    // Status command codes accepted as mask targets
    localparam logic [7:0] ST_WORD  = 8'h79;
    localparam logic [7:0] ST_VOUT  = 8'h7a;
    localparam logic [7:0] ST_IOUT  = 8'h7b;
    localparam logic [7:0] ST_INPUT = 8'h7c;
    localparam logic [7:0] ST_THERM = 8'h7d;
    localparam logic [7:0] ST_CML   = 8'h7e;
    localparam logic [7:0] ST_MFR   = 8'h80;

    // Write-guard byte: bits 7..5 kept as guard_reg[2:0]
    localparam int         GUARD_LSB   = 5;
    localparam logic [2:0] GUARD_RESET = 3'h0;
    localparam logic [2:0] GUARD_B5    = 3'h1;
    localparam logic [2:0] GUARD_B6    = 3'h2;
    localparam logic [2:0] GUARD_B7    = 3'h4;

    // Feature report fields
    localparam logic       FEAT_PEC            = 1'h1;
    localparam logic [1:0] BUS_SPEED_FIELD_400K = 2'h1;
    localparam logic       ALERT_SUPPORT_FLAG  = 1'h1;
    localparam logic [7:0] FEATURE_VALUE =
        {FEAT_PEC, BUS_SPEED_FIELD_400K, ALERT_SUPPORT_FLAG, 4'h0};

    // Alert mask store: one byte slot per status command
    localparam int          MASK_SLOTS     = 7;
    localparam logic [7:0]  MASK_BLK_COUNT = 8'h01;
    localparam logic [7:0]  MASK_BAD_READ  = 8'h00;
    // Slot order: word(hi byte), vout, iout, input, thermal, cml, mfr; 19 bits
    localparam logic [55:0] MASKABLE_BITS  = 56'h07_c3_c0_90_d0_f0_04;
    localparam logic [55:0] MASK_RESET     = 56'h00_00_00_00_00_00_04;

    // Timing
    localparam longint CLK_HZ   = 40000000;
    localparam longint BUSY_MS  = 100;
    localparam longint BUSY_CYC = BUSY_MS * CLK_HZ / 1000;
    localparam int     BUSY_W   = 22;

    typedef enum logic [1:0] {
        GL_NONE = 2'h0,
        GL_VOUT = 2'h1,
        GL_OPER = 2'h2,
        GL_SELF = 2'h3
    } pmb_guard_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_SAVE = 2'b01,
        SQ_HOLD = 2'b11,
        SQ_LOAD = 2'b10
    } pmb_seq_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] blk_cnt;
        logic [7:0] d0;
        logic [7:0] d1;
    } pmb_req_t;

    typedef struct packed {
        logic       valid;
        logic       ack;
        logic       own;
        logic [7:0] d0;
        logic [7:0] d1;
    } pmb_resp_t;

    function automatic logic [3:0] mask_slot(input logic [7:0] code);
        case (code)
            ST_WORD:  mask_slot = 4'h8;
            ST_VOUT:  mask_slot = 4'h9;
            ST_IOUT:  mask_slot = 4'ha;
            ST_INPUT: mask_slot = 4'hb;
            ST_THERM: mask_slot = 4'hc;
            ST_CML:   mask_slot = 4'hd;
            ST_MFR:   mask_slot = 4'he;
            default:  mask_slot = 4'h0;
        endcase
    endfunction

endpackage

// ### pmb_mask_mem.sv
// Live alert masks with a nonvolatile image beside them.
// Assumes save/load are single-cycle pulses from the command sequencer.
`timescale 1ns/10ps
`default_nettype none
module pmb_mask_mem
    import pmb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [7:0]  wr_data,
    input  wire logic [2:0]  rd_idx,
    output logic      [7:0]  rd_data,
    input  wire logic        save,
    input  wire logic        load,
    output logic      [55:0] live_flat
);
    logic [55:0] live_reg;
    logic [55:0] image_reg;
    logic [55:0] wr_vec;

    always_comb begin
        wr_vec = live_reg;
        // Only maskable positions hold a bit; the rest read as zero
        wr_vec[wr_idx*8 +: 8] = wr_data & MASKABLE_BITS[wr_idx*8 +: 8];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            live_reg <= MASK_RESET;
        end else if (load) begin
            live_reg <= image_reg;
        end else if (wr_en) begin
            live_reg <= wr_vec;
        end
    end

    // Image comes up as the power-up defaults
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            image_reg <= MASK_RESET;
        end else if (save) begin
            image_reg <= live_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= live_reg[rd_idx*8 +: 8];
        end
    end

    assign live_flat = live_reg;
endmodule
`default_nettype wire

// ### pmb_cmd_core.sv
// Command layer: write guard, save/restore sequencer, feature report, alert masks.
// Assumes an upstream PMBus framer delivering whole transactions on clk_sys,
// and an NVM macro and status registers on the same clock.
//
// Function
// - Guard bit5: only guard, run, switch-config, setpoint
// - Guard bit6: only guard and run-control writes
// - Guard bit7: only guard writes accepted
// - Several guard bits written: alert plus fault flag
// - Invalid guard combination means no protection
// - All supported commands stay readable always; code leaves save/restore reads unanswered and NACKs reads while busy
// - Save command copies settings into nonvolatile image
// - Faults ignored while save is running
// - About 100 ms unresponsive after save/restore
// - Failed programming: NACK, fault flag, memory flag
// - Restore reloads only unprotected registers
// - Restore while switching halts, then restarts
// - User save/restore share codes and path
// - Feature report: PEC, 400 kHz, alert support
// - Mask write: word, target code, mask byte
// - Mask read needs block count 1, else NACK
// - Mask read returns count 1 and byte
// - Set mask bit blocks matching status alert
// - Nineteen maskable sources, each nonvolatile backed
// - Bad mask target write: fault, invalid-data, alert
// - Bad mask target read returns 00h
// - Power-good-low mask via 79h, resets set
`timescale 1ns/10ps
`default_nettype none
module pmb_cmd_core
    import pmb_pkg::*;
#(
    parameter int BUSY_CYCLES = int'(BUSY_CYC)
)
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire pmb_req_t    req,
    output pmb_resp_t        resp,
    output logic             wr_grant,
    input  wire logic [55:0] status_flat,
    input  wire logic        clear_faults,
    input  wire logic        conv_switching,
    input  wire logic        nvm_done,
    input  wire logic        nvm_fail,
    output logic             nvm_prog_req,
    output logic             restore_req,
    output pmb_guard_t       restore_level,
    output logic             fault_ignore,
    output logic             conv_halt,
    output logic             cml_set,
    output logic             ivd_set,
    output logic             mem_set,
    output logic             alert_o,
    output logic             alert_oe
);
    localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(BUSY_CYCLES - 1);

    pmb_seq_t          state_reg;
    logic [BUSY_W-1:0] busy_cnt_reg;
    logic [2:0]        guard_reg;
    logic [2:0]        guard_img_reg;
    logic              own_alert_reg;
    logic              mask_pend_reg;
    logic              mask_bad_reg;
    pmb_guard_t        level;
    logic              write_ok;
    logic              is_save;
    logic              is_restore;
    logic [3:0]        slot;
    logic              mask_wr;
    logic              mem_save;
    logic              mem_load;
    logic [7:0]        mask_rd;
    logic [55:0]       mask_live;
    logic              idle_req;
    logic              save_ok;

    // Invalid combinations give no protection at all
    always_comb begin
        case (guard_reg)
            GUARD_B5: level = GL_VOUT;
            GUARD_B6: level = GL_OPER;
            GUARD_B7: level = GL_SELF;
            default:  level = GL_NONE;
        endcase
    end

    // Save and restore are not register writes; restore filters per register
    always_comb begin
        case (level)
            GL_VOUT: write_ok = (req.code == CMD_GUARD) || (req.code == CMD_OPERATION) ||
                                (req.code == CMD_ONOFF_CFG) || (req.code == CMD_VOUT);
            GL_OPER: write_ok = (req.code == CMD_GUARD) ||
                                (req.code == CMD_OPERATION);
            GL_SELF: write_ok = (req.code == CMD_GUARD);
            default: write_ok = 1'b1;
        endcase
        if (is_save || is_restore) begin
            write_ok = 1'b1;
        end
    end

    // One code serves both the default and the user variant
    assign is_save    = req.write && (req.code == CMD_SAVE);
    assign is_restore = req.write && (req.code == CMD_RESTORE);
    assign idle_req   = req.valid && (state_reg == SQ_IDLE);
    assign slot       = mask_slot(req.d0);
    assign save_ok    = (state_reg == SQ_SAVE) && nvm_done && !nvm_fail;

    // Mask write only lands when the guard lets it and the target is known
    assign mask_wr  = idle_req && req.write && (req.code == CMD_MASK) &&
                      write_ok && slot[3];
    assign mem_save = save_ok;
    assign mem_load = (state_reg == SQ_LOAD) && (level == GL_NONE);

    pmb_mask_mem u_mask (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .wr_en     (mask_wr),
        .wr_idx    (slot[2:0]),
        .wr_data   (req.d1),
        .rd_idx    (slot[2:0]),
        .rd_data   (mask_rd),
        .save      (mem_save),
        .load      (mem_load),
        .live_flat (mask_live)
    );

    // Sequencer: save waits on the NVM, then both paths sit out the busy time
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= SQ_IDLE;
            busy_cnt_reg <= '0;
            nvm_prog_req <= 1'b0;
            fault_ignore <= 1'b0;
            conv_halt    <= 1'b0;
            restore_req  <= 1'b0;
            restore_level <= GL_NONE;
        end else begin
            nvm_prog_req <= 1'b0;
            restore_req  <= 1'b0;
            case (state_reg)
                SQ_IDLE: begin
                    busy_cnt_reg <= '0;
                    if (idle_req && is_save) begin
                        state_reg    <= SQ_SAVE;
                        nvm_prog_req <= 1'b1;
                        fault_ignore <= 1'b1;
                    end else if (idle_req && is_restore) begin
                        state_reg <= SQ_LOAD;
                        conv_halt <= conv_switching;
                    end
                end
                SQ_SAVE: begin
                    if (nvm_done) begin
                        state_reg    <= SQ_HOLD;
                        fault_ignore <= 1'b0;
                    end
                end
                SQ_LOAD: begin
                    // Outside registers filter by the level taken here
                    restore_req   <= 1'b1;
                    restore_level <= level;
                    state_reg     <= SQ_HOLD;
                end
                SQ_HOLD: begin
                    busy_cnt_reg <= busy_cnt_reg + 1'b1;
                    if (busy_cnt_reg >= BUSY_LAST) begin
                        state_reg <= SQ_IDLE;
                        conv_halt <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= SQ_IDLE;
                end
            endcase
        end
    end

    // Guard register and its nonvolatile copy
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            guard_reg     <= GUARD_RESET;
            guard_img_reg <= GUARD_RESET;
        end else begin
            if (save_ok) begin
                guard_img_reg <= guard_reg;
            end
            if (state_reg == SQ_LOAD) begin
                // Guard itself is never protected, so it always reloads
                guard_reg <= guard_img_reg;
            end else if (idle_req && req.write && req.code == CMD_GUARD) begin
                guard_reg <= req.d0[GUARD_LSB +: 3];
            end
        end
    end

    // Answers, write grant and fault flag pulses
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            resp          <= '0;
            wr_grant      <= 1'b0;
            cml_set       <= 1'b0;
            ivd_set       <= 1'b0;
            mem_set       <= 1'b0;
            mask_pend_reg <= 1'b0;
            mask_bad_reg  <= 1'b0;
        end else begin
            resp          <= '0;
            wr_grant      <= 1'b0;
            cml_set       <= 1'b0;
            ivd_set       <= 1'b0;
            mem_set       <= 1'b0;
            mask_pend_reg <= 1'b0;
            if (state_reg == SQ_SAVE) begin
                if (nvm_done) begin
                    resp.valid <= 1'b1;
                    resp.own   <= 1'b1;
                    resp.ack   <= !nvm_fail;
                    cml_set    <= nvm_fail;
                    mem_set    <= nvm_fail;
                end
            end else if (mask_pend_reg) begin
                // Mask byte comes from the store one cycle after the request
                resp.valid <= 1'b1;
                resp.own   <= 1'b1;
                resp.ack   <= 1'b1;
                resp.d0    <= MASK_BLK_COUNT;
                resp.d1    <= mask_bad_reg ? MASK_BAD_READ : mask_rd;
            end else if (req.valid && state_reg != SQ_IDLE) begin
                // Unresponsive during the busy window
                resp.valid <= 1'b1;
                resp.own   <= 1'b1;
                resp.ack   <= 1'b0;
            end else if (req.valid) begin
                resp.valid <= 1'b1;
                resp.ack   <= 1'b1;
                case (req.code)
                    CMD_GUARD: begin
                        resp.own <= 1'b1;
                        resp.d0  <= {guard_reg, 5'h00};
                        if (req.write) begin
                            cml_set <= req.d0[GUARD_LSB +: 3] != 3'h0 &&
                                       req.d0[GUARD_LSB +: 3] != GUARD_B5 &&
                                       req.d0[GUARD_LSB +: 3] != GUARD_B6 &&
                                       req.d0[GUARD_LSB +: 3] != GUARD_B7;
                        end
                    end
                    CMD_SAVE, CMD_RESTORE: begin
                        resp.own <= 1'b1;
                        // Save answers once the NVM reports back
                        resp.valid <= is_restore;
                    end
                    CMD_FEATURE: begin
                        resp.own <= 1'b1;
                        resp.ack <= !req.write;
                        resp.d0  <= FEATURE_VALUE;
                    end
                    CMD_MASK: begin
                        resp.own <= 1'b1;
                        if (req.write) begin
                            resp.ack <= write_ok && slot[3];
                            cml_set  <= write_ok && !slot[3];
                            ivd_set  <= write_ok && !slot[3];
                        end else if (req.blk_cnt != MASK_BLK_COUNT) begin
                            resp.ack <= 1'b0;
                        end else begin
                            resp.valid    <= 1'b0;
                            mask_pend_reg <= 1'b1;
                            mask_bad_reg  <= !slot[3];
                        end
                    end
                    default: begin
                        resp.ack <= !req.write || write_ok;
                        wr_grant <= req.write && write_ok;
                    end
                endcase
            end
        end
    end

    // Alert line: open-drain, driven low while any unmasked cause stands
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            own_alert_reg <= 1'b0;
            alert_o       <= 1'b0;
            alert_oe      <= 1'b0;
        end else begin
            // A new fault in the clearing cycle still wins
            if (cml_set) begin
                own_alert_reg <= 1'b1;
            end else if (clear_faults) begin
                own_alert_reg <= 1'b0;
            end
            alert_o  <= 1'b0;
            alert_oe <= own_alert_reg || cml_set ||
                        (|(status_flat & ~mask_live));
        end
    end
endmodule
`default_nettype wire

// ### pmb_cmd_core_props.sv
// Checker of the command core: guard filter, store/reload, feature, masks.
// Assumes it is bound to pmb_cmd_core and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module pmb_cmd_core_props
    import pmb_pkg::*;
#(
    parameter int BUSY_CYCLES = 20
)
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire pmb_req_t    req,
    input wire pmb_resp_t   resp,
    input wire logic        wr_grant,
    input wire logic [55:0] status_flat,
    input wire logic        clear_faults,
    input wire logic        conv_switching,
    input wire logic        nvm_done,
    input wire logic        nvm_fail,
    input wire logic        nvm_prog_req,
    input wire logic        restore_req,
    input wire pmb_guard_t  restore_level,
    input wire logic        fault_ignore,
    input wire logic        conv_halt,
    input wire logic        cml_set,
    input wire logic        ivd_set,
    input wire logic        mem_set,
    input wire logic        alert_o,
    input wire logic        alert_oe
);
    logic [2:0] lvl_reg;
    logic       wr_q;

    assign wr_q = req.valid && req.write;

    // Shadow of the guard bits; a restore reload is not tracked
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            lvl_reg <= 3'h0;
        else if (wr_q && req.code == CMD_GUARD)
            lvl_reg <= req.d0[7:5];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_feature_fixed: assert property (req.valid && !req.write && req.code == CMD_FEATURE
        |=> resp.valid && resp.d0 == 8'hb0) else $error("feature report wrong");
    a_mask_count_one: assert property (req.valid && !req.write && req.code == CMD_MASK
        && req.blk_cnt == 8'h01 |-> ##2 resp.valid && resp.ack && resp.d0 == 8'h01)
        else $error("mask read count wrong");
    a_mask_count_bad: assert property (req.valid && !req.write && req.code == CMD_MASK
        && req.blk_cnt != 8'h01 |=> resp.valid && !resp.ack)
        else $error("bad block count accepted");
    a_bit7_blocks: assert property (lvl_reg == 3'h4 && wr_q && req.code != CMD_GUARD
        |=> !wr_grant) else $error("write passed full guard");
    a_bit6_run: assert property (lvl_reg == 3'h2 && wr_q && req.code == CMD_OPERATION
        |=> wr_grant) else $error("run control write blocked");
    a_bit5_level: assert property (lvl_reg == 3'h1 && wr_q && req.code == CMD_VOUT
        |=> wr_grant) else $error("setpoint write blocked");
    a_bad_guard_free: assert property ($countones(lvl_reg) > 1 && wr_q
        && req.code == CMD_VOUT |=> wr_grant) else $error("invalid guard still blocks");
    a_multi_guard: assert property (wr_q && req.code == CMD_GUARD
        && $countones(req.d0[7:5]) > 1 |-> ##[1:2] cml_set) else $error("no fault flag");
    a_save_quiet: assert property (fault_ignore && !nvm_done |=> fault_ignore)
        else $error("faults unmasked during save");
    a_fail_flags: assert property (fault_ignore && nvm_done && nvm_fail
        |=> resp.valid && !resp.ack && mem_set && cml_set) else $error("store fault lost");
    a_cml_alert: assert property (cml_set |=> alert_oe)
        else $error("fault flag without alert");

    c_store_fail: cover property (nvm_done && nvm_fail);
    c_halted_reload: cover property (restore_req && conv_halt);
    c_busy_refusal: cover property (resp.valid && resp.own && !resp.ack);
endmodule
`default_nettype wire

// ### pmb_nvm_model.sv
// Behavioural nonvolatile store macro facing the command core.
// Assumes prog_req is a one-cycle pulse; slow and fail_mode come from the bench.
`timescale 1ns/10ps
`default_nettype none
module pmb_nvm_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic prog_req,
    input  wire logic slow,
    input  wire logic fail_mode,
    output logic      nvm_done,
    output logic      nvm_fail
);
    logic [5:0] cnt_reg;

    // Programming takes 2 or 40 cycles, result given with the done pulse
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg  <= 6'h00;
            nvm_done <= 1'b0;
            nvm_fail <= 1'b0;
        end else begin
            nvm_done <= (cnt_reg == 6'h01);
            // Fail line is only valid with done, toggles otherwise
            nvm_fail <= (cnt_reg == 6'h01) ? fail_mode : ~nvm_fail;
            if (prog_req)
                cnt_reg <= slow ? 6'h28 : 6'h02;
            else if (cnt_reg != 6'h00)
                cnt_reg <= cnt_reg - 6'h01;
        end
    end
endmodule
`default_nettype wire

// ### pmb_cmd_core_tb.sv
// Self-checking bench of the command core with a store macro model.
// Assumes a shortened busy hold of 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module pmb_cmd_core_tb;
    import pmb_pkg::*;
    localparam int BUSY = 20;
    typedef struct packed {
        logic w; logic [7:0] c, b, x, y; logic a; logic [7:0] e0, e1;
    } pmb_row_t;
    pmb_row_t rows [9] = '{
        '{1'b0, 8'h10, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 8'h00},
        '{1'b0, 8'h19, 8'h00, 8'h00, 8'h00, 1'b1, 8'hb0, 8'h00},
        '{1'b1, 8'h19, 8'h00, 8'h12, 8'h00, 1'b0, 8'h00, 8'h00},
        '{1'b0, 8'h1b, 8'h01, 8'h79, 8'h00, 1'b1, 8'h01, 8'h04},
        '{1'b0, 8'h1b, 8'h02, 8'h79, 8'h00, 1'b0, 8'h00, 8'h00},
        '{1'b1, 8'h1b, 8'h00, 8'h7d, 8'h40, 1'b1, 8'h00, 8'h00},
        '{1'b0, 8'h1b, 8'h01, 8'h7d, 8'h00, 1'b1, 8'h01, 8'h40},
        '{1'b0, 8'h1b, 8'h01, 8'h55, 8'h00, 1'b1, 8'h01, 8'h00},
        '{1'b1, 8'h21, 8'h00, 8'h33, 8'h00, 1'b1, 8'h00, 8'h00}};
    logic [7:0]  gv [3] = '{8'h20, 8'h40, 8'h80};
    logic [7:0]  wc [3] = '{CMD_OPERATION, CMD_ONOFF_CFG, CMD_VOUT};
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    pmb_req_t    req = '0;
    pmb_resp_t   resp, r;
    pmb_guard_t  restore_level, lv;
    logic [55:0] status_flat = 56'h04;
    logic        clear_faults = 1'b0, conv_switching = 1'b0, slow = 1'b0, fail_mode = 1'b0;
    logic        wr_grant, nvm_prog_req, restore_req, fault_ignore, conv_halt, nvm_done;
    logic        nvm_fail, cml_set, ivd_set, mem_set, alert_o, alert_oe;
    logic        g, cs, is, ms, fi, hl, ao;
    int          mismatches = 0, checks = 0;

    pmb_cmd_core #(.BUSY_CYCLES(BUSY)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
        .req(req), .resp(resp), .wr_grant(wr_grant), .status_flat(status_flat),
        .clear_faults(clear_faults), .conv_switching(conv_switching), .nvm_done(nvm_done),
        .nvm_fail(nvm_fail), .nvm_prog_req(nvm_prog_req), .restore_req(restore_req),
        .restore_level(restore_level), .fault_ignore(fault_ignore), .conv_halt(conv_halt),
        .cml_set(cml_set), .ivd_set(ivd_set), .mem_set(mem_set), .alert_o(alert_o),
        .alert_oe(alert_oe));
    pmb_nvm_model u_nvm (.clk_sys(clk_sys), .resetn(resetn), .prog_req(nvm_prog_req),
        .slow(slow), .fail_mode(fail_mode), .nvm_done(nvm_done), .nvm_fail(nvm_fail));

    always #12.5 clk_sys = ~clk_sys;

    // Mid-cycle sampling keeps pulses clear of the launching edge
    always @(negedge clk_sys) begin
        g |= wr_grant; cs |= cml_set; is |= ivd_set; ms |= mem_set;
        fi |= fault_ignore; hl |= conv_halt; ao = alert_oe;
        if (restore_req === 1'b1) lv = restore_level;
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One whole transaction, then two quiet cycles for late pulses
    task automatic cmd(input logic w, input logic [7:0] c, b, x, y);
        int n;
        n = 0; g = 0; cs = 0; is = 0; ms = 0; fi = 0; hl = 0;
        @(posedge clk_sys) req <= '{1'b1, w, c, b, x, y};
        @(posedge clk_sys) req <= '0;
        #1;
        while (resp.valid !== 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        r = resp;
        if (n == 200) chk("answer", 8'h00, 8'h01);
        idle(2);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        idle(6000);
        mismatches++;
        report_and_stop();
    end

    initial begin
        idle(16);
        resetn <= 1'b1;
        idle(3);
        chk("pgood alert", 8'(ao), 8'h00);
        foreach (rows[i]) begin
            cmd(rows[i].w, rows[i].c, rows[i].b, rows[i].x, rows[i].y);
            chk("ack", 8'(r.ack), 8'(rows[i].a));
            if (!rows[i].w) chk("d0", r.d0, rows[i].e0);
            if (!rows[i].w && rows[i].c == CMD_MASK) chk("d1", r.d1, rows[i].e1);
        end
        foreach (gv[k]) begin
            cmd(1'b1, CMD_GUARD, 8'h00, gv[k], 8'h00);
            foreach (wc[j]) begin
                cmd(1'b1, wc[j], 8'h00, 8'h01, 8'h00);
                chk("grant", 8'(g), 8'((j == 0 && k < 2) || k == 0));
                cmd(1'b0, wc[j], 8'h00, 8'h00, 8'h00);
                chk("read ack", 8'(r.ack), 8'h01);
            end
        end
        cmd(1'b1, CMD_MASK, 8'h00, ST_THERM, 8'h00);
        chk("guarded mask", 8'(r.ack), 8'h00);
        conv_switching <= 1'b1;
        cmd(1'b1, CMD_RESTORE, 8'h00, 8'h00, 8'h00);
        chk("restore ack", 8'(r.ack), 8'h01);
        idle(BUSY + 5);
        chk("restore level", 8'(lv), 8'(GL_SELF));
        chk("halt seen", 8'(hl), 8'h01);
        chk("halt end", 8'(conv_halt), 8'h00);
        conv_switching <= 1'b0;
        cmd(1'b1, CMD_GUARD, 8'h00, 8'h60, 8'h00);
        chk("multi cml", 8'(cs), 8'h01);
        cmd(1'b1, CMD_VOUT, 8'h00, 8'h01, 8'h00);
        chk("free grant", 8'(g), 8'h01);
        cmd(1'b1, CMD_GUARD, 8'h00, 8'h00, 8'h00);
        cmd(1'b0, CMD_MASK, 8'h01, ST_THERM, 8'h00);
        chk("kept mask", r.d1, 8'h40);
        cmd(1'b1, CMD_MASK, 8'h00, 8'h55, 8'hff);
        chk("bad tgt", {5'h0, r.ack, cs, is}, 8'h03);
        chk("bad tgt alert", {6'h0, alert_o, ao}, 8'h01);
        @(posedge clk_sys) clear_faults <= 1'b1;
        @(posedge clk_sys) clear_faults <= 1'b0;
        status_flat <= 56'h00_00_40_00_00_00_04;
        idle(4);
        chk("masked", 8'(ao), 8'h00);
        status_flat <= 56'h00_00_80_00_00_00_04;
        idle(4);
        chk("unmasked", 8'(ao), 8'h01);
        slow <= 1'b1;
        cmd(1'b1, CMD_SAVE, 8'h00, 8'h00, 8'h00);
        chk("save", {6'h0, r.ack, fi}, 8'h03);
        cmd(1'b0, CMD_GUARD, 8'h00, 8'h00, 8'h00);
        chk("busy", {6'h0, r.own, r.ack}, 8'h02);
        idle(BUSY + 5);
        slow <= 1'b0;
        fail_mode <= 1'b1;
        cmd(1'b1, CMD_SAVE, 8'h00, 8'h00, 8'h00);
        chk("fail", {5'h0, r.ack, cs, ms}, 8'h03);
        idle(BUSY + 5);
        resetn <= 1'b0;
        idle(3);
        resetn <= 1'b1;
        cmd(1'b0, CMD_GUARD, 8'h00, 8'h00, 8'h00);
        chk("guard reset", r.d0, 8'h00);
        report_and_stop();
    end
endmodule

bind pmb_cmd_core pmb_cmd_core_props #(.BUSY_CYCLES(BUSY_CYCLES)) u_props (
    .clk_sys(clk_sys), .resetn(resetn), .req(req), .resp(resp), .wr_grant(wr_grant),
    .status_flat(status_flat), .clear_faults(clear_faults), .conv_switching(conv_switching),
    .nvm_done(nvm_done), .nvm_fail(nvm_fail), .nvm_prog_req(nvm_prog_req),
    .restore_req(restore_req), .restore_level(restore_level), .fault_ignore(fault_ignore),
    .conv_halt(conv_halt), .cml_set(cml_set), .ivd_set(ivd_set), .mem_set(mem_set),
    .alert_o(alert_o), .alert_oe(alert_oe));
`default_nettype wire
